// ---- logic/pcg_cfg.svh ----
// Purpose: constants for the programmable clock generator controller
// Assumes: word-wide register writes from the cpu side only
// Notes:   field positions, offsets and reset values live here
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH

`define PCG_ADDR_CSR         32'h01b7c100
`define PCG_ADDR_MULT        32'h01b7c110
`define PCG_ADDR_DIV0        32'h01b7c114
`define PCG_ADDR_DIV1        32'h01b7c118
`define PCG_ADDR_DIV2        32'h01b7c11c
`define PCG_ADDR_DIV3        32'h01b7c120
`define PCG_ADDR_OSC         32'h01b7c124

`define PCG_CSR_PATH_BIT     0
`define PCG_CSR_PWRDN_BIT    1
`define PCG_CSR_RST_BIT      3
`define PCG_CSR_STABLE_BIT   6
`define PCG_DIV_EN_BIT       15
`define PCG_RATIO_MSB        4

`define PCG_MULT_RST         5'h07
`define PCG_DIV0_RST         5'h00
`define PCG_DIV1_RST         5'h00
`define PCG_DIV2_RST         5'h01
`define PCG_DIV3_RST         5'h01
`define PCG_OSC_RST          5'h07

`define PCG_RESET_TIME_NS    125
`define PCG_LOCK_TYP_US      75
`define PCG_LOCK_MAX_NS      187500
`define PCG_CLK_MHZ          200
`define PCG_OSC_SETTLE_CYC   4096

`endif

// ---- logic/pcg_pkg.sv ----
// Purpose: shared types of the clock generator controller
// Assumes: nothing beyond the cfg header
// Notes:   divider slots index the divider interface array
package pcg_pkg;
    typedef logic [4:0] pcg_ratio_t;
    typedef enum logic [2:0] {
        PCG_DV_PRE  = 3'h0,
        PCG_DV_CORE = 3'h1,
        PCG_DV_BUS  = 3'h2,
        PCG_DV_MEM  = 3'h3,
        PCG_DV_OSC  = 3'h4
    } pcg_slot_t;
    localparam int PCG_NDIV = 5;
endpackage : pcg_pkg

// ---- logic/pcg_div_if.sv ----
// Purpose: carries one divider's source tick, setting and output pulse
// Assumes: all signals on clk_in
// Notes:   ctl side drives tick, ratio and enable
`timescale 1ns/10ps
`default_nettype none
interface pcg_div_if;
    import pcg_pkg::*;
    logic       tick;
    pcg_ratio_t ratio;
    logic       enable;
    logic       pulse;
    modport ctl (output tick, output ratio, output enable, input pulse);
    modport div (input tick, input ratio, input enable, output pulse);
endinterface : pcg_div_if
`default_nettype wire

// ---- logic/pcg_divider.sv ----
// Purpose: divides a tick stream by ratio+1, one pulse per divided period
// Assumes: tick is a one-cycle enable on clk_in
// Notes:   a new ratio is taken at the period boundary, or every cycle while the divider is disabled
`timescale 1ns/10ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_divider import pcg_pkg::*; (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic ce_in,
    pcg_div_if.div    bus
);
    pcg_ratio_t cnt_r, cnt_nxt;
    pcg_ratio_t act_r, act_nxt;
    logic       pulse_r, pulse_nxt;
    logic       wrap;

    assign wrap = bus.tick && (cnt_r == act_r);

    always_comb begin
        cnt_nxt   = cnt_r;
        act_nxt   = act_r;
        pulse_nxt = 1'b0;
        if (!bus.enable) begin               // [RL21]
            cnt_nxt = '0;
            act_nxt = bus.ratio;
        end else if (wrap) begin
            cnt_nxt   = '0;
            act_nxt   = bus.ratio;             // [RL23] [RL20]
            pulse_nxt = 1'b1;
        end else if (bus.tick) begin
            cnt_nxt = cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_r   <= '0;
            act_r   <= '0;
            pulse_r <= 1'b0;
        end else if (ce_in) begin
            cnt_r   <= cnt_nxt;
            act_r   <= act_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign bus.pulse = pulse_r;

    // ticks since the last pulse, read only by the checks below
    pcg_ratio_t gap_r;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gap_r <= '0;
        end else if (ce_in && bus.tick) begin
            gap_r <= wrap ? 5'h00 : gap_r + 5'h01;
        end
    end

    a_disabled_silent: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL21]
        (ce_in && !bus.enable) |=> !bus.pulse)
        else $error("disabled divider produced a pulse");
    a_period_whole: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL23]
        (ce_in && bus.enable && wrap && $past(bus.pulse)) |-> (gap_r == act_r))
        else $error("divided period cut short");
    c_div_pulse: cover property (@(posedge clk_in) disable iff (!rstn_in)
        bus.pulse ##1 !bus.pulse [*2] ##1 bus.pulse);
endmodule : pcg_divider
`default_nettype wire

// ---- logic/pcg_clock_ctrl.sv ----
// Purpose: programmable clock generator control, dividers and output gating
// Assumes: clk_in is the reference input clock; pll_tick_in is the
//          analog multiplier output presented as an enable on clk_in
// Notes:   output clocks are one-cycle enable pulses per divided period, except memory_clock_output_out with the external pin selected
//
// Summary of operation
// RL1 - hold pll reset at least 125 ns
// RL2 - wait lock time before leaving bypass
// RL3 - clock two needs bus enable and gate
// RL4 - clock three divides raw input clock
// RL5 - memory clock source select and enable
// RL6 - prescale then multiply x4 to x25
// RL7 - path select picks bypass or pll
// RL8 - three post-dividers from selected reference
// RL9 - software keeps pll frequencies in range
// RL10 - bus clock exactly half core clock
// RL11 - clock two comes from bus clock
// RL12 - order divider writes by direction
// RL13 - bypass while changing pll input
// RL14 - never disable core or bus divider
// RL15 - only cpu touches these registers
// RL16 - stable flag zero until counter done
// RL17 - reset bit drives pll reset
// RL18 - software writes zero to bit two
// RL19 - power down bit drives pll
// RL20 - reprogram anything while running
// RL21 - disabled divider gives no clock
// RL22 - divider three off only with external
// RL23 - changes land on period boundaries
// RL24 - reserved bits read zero
`timescale 1ns/10ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_clock_ctrl import pcg_pkg::*; #(
    parameter int OSC_SETTLE_CYC = `PCG_OSC_SETTLE_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [31:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        pll_tick_in,
    input  wire logic        memory_clock_input_in,
    input  wire logic        clk_out_two_enable_in,
    input  wire logic        memclk_out_enable_in,
    input  wire logic        memclk_source_select_in,
    output logic             pll_reset_out,
    output logic             pll_power_down_out,
    output logic      [4:0]  pll_mult_out,
    output logic             pll_reference_out,
    output logic             core_clock_out,
    output logic             peripheral_bus_clock_out,
    output logic             memory_if_clock_out,
    output logic             clock_output_two_out,
    output logic             clock_output_three_out,
    output logic             memory_clock_output_out
);
    // reset and lock waits are left to software; the hardware does not police them
    // reset release through two flops
    logic rst_s1_r, rstn_r;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_s1_r <= 1'b0;
            rstn_r   <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rstn_r   <= rst_s1_r;
        end
    end

    function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // register state
    logic       path_r, path_nxt;
    logic       pwrdn_r, pwrdn_nxt;
    logic       prst_r, prst_nxt;
    pcg_ratio_t mult_r, mult_nxt;
    pcg_ratio_t ratio_r [PCG_NDIV];
    pcg_ratio_t ratio_nxt [PCG_NDIV];
    logic [PCG_NDIV-1:0] en_r, en_nxt;
    logic [31:0] rdata_nxt;
    logic [31:0] div_addr [PCG_NDIV];

    assign div_addr[PCG_DV_PRE]  = `PCG_ADDR_DIV0;
    assign div_addr[PCG_DV_CORE] = `PCG_ADDR_DIV1;
    assign div_addr[PCG_DV_BUS]  = `PCG_ADDR_DIV2;
    assign div_addr[PCG_DV_MEM]  = `PCG_ADDR_DIV3;
    assign div_addr[PCG_DV_OSC]  = `PCG_ADDR_OSC;

    // oscillator settle counter behind the stable flag
    logic [15:0] osc_cnt_r, osc_cnt_nxt;
    logic        stable_r, stable_nxt;

    always_comb begin
        osc_cnt_nxt = osc_cnt_r;
        stable_nxt  = stable_r;
        if (!stable_r) begin
            if (osc_cnt_r == 16'(OSC_SETTLE_CYC - 1)) begin
                stable_nxt = 1'b1;                              // [RL16]
            end else begin
                osc_cnt_nxt = osc_cnt_r + 16'h0001;
            end
        end
    end

    always_comb begin
        path_nxt  = path_r;
        pwrdn_nxt = pwrdn_r;
        prst_nxt  = prst_r;
        mult_nxt  = mult_r;
        ratio_nxt = ratio_r;
        en_nxt    = en_r;
        rdata_nxt = '0;
        if (reg_wr_in && hit(reg_addr_in, `PCG_ADDR_CSR)) begin
            path_nxt  = reg_wdata_in[`PCG_CSR_PATH_BIT];         // [RL7]
            pwrdn_nxt = reg_wdata_in[`PCG_CSR_PWRDN_BIT];        // [RL19]
            prst_nxt  = reg_wdata_in[`PCG_CSR_RST_BIT];          // [RL17]
        end
        if (reg_wr_in && hit(reg_addr_in, `PCG_ADDR_MULT)) begin
            mult_nxt = reg_wdata_in[`PCG_RATIO_MSB:0];           // [RL6] [RL20]
        end
        for (int i = 0; i < PCG_NDIV; i++) begin
            if (reg_wr_in && hit(reg_addr_in, div_addr[i])) begin
                ratio_nxt[i] = reg_wdata_in[`PCG_RATIO_MSB:0];   // [RL20]
                en_nxt[i]    = reg_wdata_in[`PCG_DIV_EN_BIT];
            end
            if (reg_rd_in && hit(reg_addr_in, div_addr[i])) begin
                rdata_nxt[`PCG_RATIO_MSB:0] = ratio_r[i];
                rdata_nxt[`PCG_DIV_EN_BIT]  = en_r[i];
            end
        end
        if (reg_rd_in && hit(reg_addr_in, `PCG_ADDR_CSR)) begin
            rdata_nxt[`PCG_CSR_PATH_BIT]   = path_r;             // [RL24]
            rdata_nxt[`PCG_CSR_PWRDN_BIT]  = pwrdn_r;
            rdata_nxt[`PCG_CSR_RST_BIT]    = prst_r;
            rdata_nxt[`PCG_CSR_STABLE_BIT] = stable_r;           // [RL16]
        end
        if (reg_rd_in && hit(reg_addr_in, `PCG_ADDR_MULT)) begin
            rdata_nxt[`PCG_RATIO_MSB:0] = mult_r;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            path_r        <= 1'b0;
            pwrdn_r       <= 1'b0;
            prst_r        <= 1'b1;
            mult_r        <= `PCG_MULT_RST;
            ratio_r[PCG_DV_PRE]  <= `PCG_DIV0_RST;
            ratio_r[PCG_DV_CORE] <= `PCG_DIV1_RST;
            ratio_r[PCG_DV_BUS]  <= `PCG_DIV2_RST;
            ratio_r[PCG_DV_MEM]  <= `PCG_DIV3_RST;
            ratio_r[PCG_DV_OSC]  <= `PCG_OSC_RST;
            en_r          <= '1;                                 // [RL3] [RL4] [RL21]
            reg_rdata_out <= '0;
            osc_cnt_r     <= '0;
            stable_r      <= 1'b0;
        end else if (ce_in) begin
            path_r        <= path_nxt;
            pwrdn_r       <= pwrdn_nxt;
            prst_r        <= prst_nxt;
            mult_r        <= mult_nxt;
            ratio_r       <= ratio_nxt;
            en_r          <= en_nxt;
            reg_rdata_out <= rdata_nxt;
            osc_cnt_r     <= osc_cnt_nxt;
            stable_r      <= stable_nxt;
        end
    end

    assign pll_reset_out      = prst_r;                          // [RL17]
    assign pll_power_down_out = pwrdn_r;                         // [RL19]
    assign pll_mult_out       = mult_r;                          // [RL6]

    // path select takes effect only on a reference tick, so no runt edge
    logic path_act_r, path_act_nxt;
    logic hf_tick;
    assign hf_tick = path_act_r ? pll_tick_in : 1'b1;            // [RL7]
    always_comb begin
        path_act_nxt = path_act_r;
        if (hf_tick) begin
            path_act_nxt = path_r;                               // [RL23]
        end
    end

    // external memory clock pin: three flops, accept when last two agree
    logic [2:0] ek_sync_r, ek_sync_nxt;
    logic       ek_lvl_r, ek_lvl_nxt;
    always_comb begin
        ek_sync_nxt = {ek_sync_r[1:0], memory_clock_input_in};
        ek_lvl_nxt  = (ek_sync_r[1] == ek_sync_r[2]) ? ek_sync_r[2] : ek_lvl_r;
    end

    pcg_div_if dif [PCG_NDIV] ();
    logic [PCG_NDIV-1:0] pulse;

    genvar g;
    generate
        for (g = 0; g < PCG_NDIV; g++) begin : g_div
            // prescaler and oscillator divider see the raw input clock
            assign dif[g].tick   = (g == PCG_DV_PRE || g == PCG_DV_OSC) ?
                                   1'b1 : hf_tick;              // [RL4] [RL8]
            assign dif[g].ratio  = ratio_r[g];
            assign dif[g].enable = en_r[g];
            assign pulse[g]      = dif[g].pulse;
            pcg_divider u_div (
                .clk_in  (clk_in),
                .rstn_in (rstn_r),
                .ce_in   (ce_in),
                .bus     (dif[g].div)
            );
        end
    endgenerate

    logic out2_r, out2_nxt;
    logic ekout_r, ekout_nxt;
    always_comb begin
        out2_nxt  = pulse[PCG_DV_BUS] && clk_out_two_enable_in;  // [RL3] [RL11]
        ekout_nxt = memclk_out_enable_in &&
                    (memclk_source_select_in ? ek_lvl_r : pulse[PCG_DV_MEM]); // [RL5]
    end

    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            path_act_r <= 1'b0;
            ek_sync_r  <= '0;
            ek_lvl_r   <= 1'b0;
            out2_r     <= 1'b0;
            ekout_r    <= 1'b0;
        end else if (ce_in) begin
            path_act_r <= path_act_nxt;
            ek_sync_r  <= ek_sync_nxt;
            ek_lvl_r   <= ek_lvl_nxt;
            out2_r     <= out2_nxt;
            ekout_r    <= ekout_nxt;
        end
    end

    assign pll_reference_out        = pulse[PCG_DV_PRE];         // [RL6]
    assign core_clock_out           = pulse[PCG_DV_CORE];        // [RL8]
    assign peripheral_bus_clock_out = pulse[PCG_DV_BUS];
    assign memory_if_clock_out      = pulse[PCG_DV_MEM];
    assign clock_output_three_out   = pulse[PCG_DV_OSC];         // [RL4]
    assign clock_output_two_out     = out2_r;
    assign memory_clock_output_out  = ekout_r;

    a_stable_waits: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL16]
        (osc_cnt_r != 16'(OSC_SETTLE_CYC - 1) && !stable_r) |-> !stable_nxt ##1 !stable_r)
        else $error("stable flag set before settle count ended");
    a_csr_reset_bit: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL17]
        (ce_in && reg_wr_in && hit(reg_addr_in, `PCG_ADDR_CSR))
        |=> pll_reset_out == $past(reg_wdata_in[`PCG_CSR_RST_BIT]))
        else $error("pll reset does not follow its control bit");
    a_csr_pwrdn_bit: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL19]
        (ce_in && reg_wr_in && hit(reg_addr_in, `PCG_ADDR_CSR))
        |=> pll_power_down_out == $past(reg_wdata_in[`PCG_CSR_PWRDN_BIT]))
        else $error("pll power down does not follow its control bit");
    a_csr_reserved_zero: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL24]
        (ce_in && reg_rd_in && hit(reg_addr_in, `PCG_ADDR_CSR))
        |=> (reg_rdata_out[31:7] == '0 && reg_rdata_out[5:4] == '0 && !reg_rdata_out[2]))
        else $error("reserved status bits read nonzero");
    a_out_two_gate: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL3]
        ($past(ce_in) && clock_output_two_out)
        |-> $past(pulse[PCG_DV_BUS] && clk_out_two_enable_in))
        else $error("clock two pulsed without bus clock and gate");
    a_memclk_source: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL5]
        (ce_in && memclk_out_enable_in && !memclk_source_select_in)
        |=> memory_clock_output_out == $past(pulse[PCG_DV_MEM]))
        else $error("memory clock output not taken from internal divider");
    a_bypass_ticks: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL7]
        (ce_in && !path_r && hf_tick) |=> !path_act_r)
        else $error("bypass not taken within one reference tick");
    a_mult_write: assert property (@(posedge clk_in) disable iff (!rstn_r) // [RL6]
        (ce_in && reg_wr_in && hit(reg_addr_in, `PCG_ADDR_MULT))
        |=> pll_mult_out == $past(reg_wdata_in[`PCG_RATIO_MSB:0]))
        else $error("multiplier write not applied");
    c_leave_bypass: cover property (@(posedge clk_in) disable iff (!rstn_r)
        !path_act_r ##1 path_act_r);
    c_stable_set: cover property (@(posedge clk_in) disable iff (!rstn_r)
        $rose(stable_r));
    c_ext_memclk: cover property (@(posedge clk_in) disable iff (!rstn_r)
        memclk_source_select_in && memory_clock_output_out);
endmodule : pcg_clock_ctrl
`default_nettype wire

// ---- dv/pcg_clock_ctrl_tb.sv ----
// Purpose: self-checking bench for the clock generator controller
// Assumes: register map and reset values as in the cfg header
// Notes:   settle count shortened; pll output modelled as a tick every other cycle
`timescale 1ns/10ps
`default_nettype none
`include "pcg_cfg.svh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g));
module pcg_clock_ctrl_tb;
    localparam int SETTLE   = 40;
    localparam int LOCK_CYC = `PCG_LOCK_MAX_NS / 5;
    logic        clk_in                  = 1'b0;
    logic        rstn_in                 = 1'b0;
    logic        ce_in                   = 1'b1;
    logic        reg_wr_in               = 1'b0;
    logic        reg_rd_in               = 1'b0;
    logic [31:0] reg_addr_in             = 32'h0;
    logic [31:0] reg_wdata_in            = 32'h0;
    logic        pll_tick_in             = 1'b0;
    logic        memory_clock_input_in   = 1'b0;
    logic        clk_out_two_enable_in   = 1'b1;
    logic        memclk_out_enable_in    = 1'b1;
    logic        memclk_source_select_in = 1'b0;
    logic        tick_on                 = 1'b0;
    wire  [31:0] reg_rdata_out;
    wire         pll_reset_out, pll_power_down_out, pll_reference_out;
    wire  [4:0]  pll_mult_out;
    wire         core_clock_out, peripheral_bus_clock_out, memory_if_clock_out;
    wire         clock_output_two_out, clock_output_three_out, memory_clock_output_out;
    int          err_total = 0;
    int          compares  = 0;

    pcg_clock_ctrl #(.OSC_SETTLE_CYC(SETTLE)) pcg_clock_ctrl_i (
        .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .pll_tick_in(pll_tick_in), .memory_clock_input_in(memory_clock_input_in),
        .clk_out_two_enable_in(clk_out_two_enable_in),
        .memclk_out_enable_in(memclk_out_enable_in),
        .memclk_source_select_in(memclk_source_select_in),
        .pll_reset_out(pll_reset_out), .pll_power_down_out(pll_power_down_out),
        .pll_mult_out(pll_mult_out), .pll_reference_out(pll_reference_out),
        .core_clock_out(core_clock_out),
        .peripheral_bus_clock_out(peripheral_bus_clock_out),
        .memory_if_clock_out(memory_if_clock_out),
        .clock_output_two_out(clock_output_two_out),
        .clock_output_three_out(clock_output_three_out),
        .memory_clock_output_out(memory_clock_output_out)
    );

    always #2.5 clk_in = ~clk_in;
    // pll stand-in: one tick every second reference cycle
    always @(negedge clk_in) pll_tick_in <= tick_on ? ~pll_tick_in : 1'b0;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge clk_in);
        reg_wr_in    = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
        @(negedge clk_in);
        reg_rd_in   = 1'b1;
        reg_addr_in = a;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        chk(n, e, reg_rdata_out);
    endtask : rd

    function automatic logic sel(input int k);
        case (k)
            0: return core_clock_out;
            1: return peripheral_bus_clock_out;
            2: return memory_if_clock_out;
            3: return clock_output_two_out;
            4: return clock_output_three_out;
            5: return memory_clock_output_out;
            default: return pll_reference_out;
        endcase
    endfunction : sel

    task automatic next_high(input int k, output int n);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (sel(k) !== 1'b1 && n < 300);
    endtask : next_high

    // two pulses are skipped so an old ratio has run out before measuring
    task automatic period(input int k, input int e, input string nm);
        int n;
        next_high(k, n);
        next_high(k, n);
        next_high(k, n);
        chk(nm, e, n);
    endtask : period

    task automatic t_reset;
        rd(`PCG_ADDR_CSR, 32'h8, "csr after reset");
        `CHK("pll reset pin", 1, pll_reset_out)
        `CHK("power down pin", 0, pll_power_down_out)
        `CHK("mult pins", `PCG_MULT_RST, pll_mult_out)
        rd(`PCG_ADDR_MULT, 32'h7, "mult reset");
        rd(`PCG_ADDR_DIV0, 32'h8000, "div0 reset");
        rd(`PCG_ADDR_DIV1, 32'h8000, "div1 reset");
        rd(`PCG_ADDR_DIV2, 32'h8001, "div2 reset");
        rd(`PCG_ADDR_DIV3, 32'h8001, "div3 reset");
        rd(`PCG_ADDR_OSC, 32'h8007, "osc reset");
        rd(32'h01b7c104, 32'h0, "unmapped read");
        repeat (SETTLE) @(negedge clk_in);
        rd(`PCG_ADDR_CSR, 32'h48, "csr stable");
        $display("test reset done");
    endtask : t_reset

    task automatic t_csr;
        ce_in = 1'b0;
        wr(`PCG_ADDR_CSR, 32'h0);
        ce_in = 1'b1;
        `CHK("frozen write", 1, pll_reset_out)
        wr(`PCG_ADDR_CSR, 32'hfffffffa);
        rd(`PCG_ADDR_CSR, 32'h4a, "csr reserved");
        `CHK("power down set", 1, pll_power_down_out)
        wr(`PCG_ADDR_CSR, 32'h8);
        repeat (30) @(negedge clk_in);
        wr(`PCG_ADDR_CSR, 32'h0);
        `CHK("pll reset released", 0, pll_reset_out)
        `CHK("power down clear", 0, pll_power_down_out)
        wr(`PCG_ADDR_DIV0, 32'hffffffff);
        rd(`PCG_ADDR_DIV0, 32'h801f, "div reserved");
        $display("test csr done");
    endtask : t_csr

    task automatic t_periods;
        int exp_p [7] = '{3, 6, 4, 6, 5, 4, 3};
        wr(`PCG_ADDR_DIV2, 32'h8005);
        wr(`PCG_ADDR_DIV1, 32'h8002);
        wr(`PCG_ADDR_DIV3, 32'h8003);
        wr(`PCG_ADDR_OSC, 32'h8004);
        wr(`PCG_ADDR_DIV0, 32'h8002);
        for (int k = 0; k < 7; k++) begin
            period(k, exp_p[k], "bypass period");
        end
        $display("test periods done");
    endtask : t_periods

    task automatic t_clock_two;
        logic prev;
        for (int g = 0; g < 3; g++) begin
            clk_out_two_enable_in = (g != 1);
            if (g == 2) wr(`PCG_ADDR_OSC, 32'h0004);
            repeat (8) @(negedge clk_in);
            prev = peripheral_bus_clock_out;
            for (int i = 0; i < 24; i++) begin
                @(negedge clk_in);
                `CHK("clock two", prev & clk_out_two_enable_in, clock_output_two_out)
                if (g == 2) `CHK("osc off", 0, clock_output_three_out)
                prev = peripheral_bus_clock_out;
            end
        end
        wr(`PCG_ADDR_OSC, 32'h8004);
        period(4, 5, "osc back on");
        $display("test clock two done");
    endtask : t_clock_two

    task automatic t_pll;
        wr(`PCG_ADDR_MULT, 32'hffffffe4);
        `CHK("mult x4", 5'h04, pll_mult_out)
        wr(`PCG_ADDR_MULT, 32'h19);
        rd(`PCG_ADDR_MULT, 32'h19, "mult x25");
        tick_on = 1'b1;
        repeat (LOCK_CYC) @(negedge clk_in);
        wr(`PCG_ADDR_CSR, 32'h1);
        period(0, 6, "pll core");
        period(1, 12, "pll bus");
        period(4, 5, "osc on raw clock");
        period(6, 3, "prescaler on raw clock");
        wr(`PCG_ADDR_CSR, 32'h0);
        period(0, 3, "bypass core again");
        tick_on = 1'b0;
        $display("test pll done");
    endtask : t_pll

    task automatic t_memclk;
        memclk_source_select_in = 1'b1;
        memory_clock_input_in   = 1'b1;
        repeat (8) @(negedge clk_in);
        `CHK("ext clock high", 1, memory_clock_output_out)
        memory_clock_input_in = 1'b0;
        repeat (8) @(negedge clk_in);
        `CHK("ext clock low", 0, memory_clock_output_out)
        memory_clock_input_in = 1'b1;
        memclk_out_enable_in  = 1'b0;
        repeat (8) @(negedge clk_in);
        `CHK("ext clock gated", 0, memory_clock_output_out)
        memclk_out_enable_in = 1'b1;
        // divider three may only be stopped while the external clock feeds memory
        wr(`PCG_ADDR_DIV3, 32'h0003);
        repeat (4) @(negedge clk_in);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_in);
            `CHK("mem divider off", 0, memory_if_clock_out)
            `CHK("ext clock kept", 1, memory_clock_output_out)
        end
        wr(`PCG_ADDR_DIV3, 32'h8003);
        memclk_source_select_in = 1'b0;
        period(5, 4, "internal memory clock");
        $display("test memory clock done");
    endtask : t_memclk

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // the lock wait dominates the run, so the limit sits well above it
    initial begin
        repeat (LOCK_CYC + 20000) @(posedge clk_in);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (20) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        t_reset();
        t_csr();
        t_periods();
        t_clock_two();
        t_pll();
        t_memclk();
        complete_run();
    end
endmodule : pcg_clock_ctrl_tb
`default_nettype wire
